// [hw/pkm_pkg.sv]
// package: constants, types and helpers for the panel key map and motion inhibit block
package pkm_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int PKM_PANELS   = 8;
  localparam int PKM_CHANNELS = 4;
  localparam int PKM_SETS     = PKM_PANELS + 1;
  localparam int PKM_JOGS     = 15;

  // ----------------------------------------
  // key word field positions
  // ----------------------------------------
  localparam int PKM_W1_JOG_LSB   = 16;
  localparam int PKM_W2_FEED_LSB  = 16;
  localparam int PKM_W2_MOVE_LSB  = 24;
  localparam int PKM_W2_OVR_UP    = 0;
  localparam int PKM_W2_OVR_DN    = 4;
  localparam int PKM_W2_STOP      = 7;
  localparam logic [15:0] PKM_W2_KEY_MASK = 16'hE7FF;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [11:0] PKM_KEY_BASE   = 12'h000;
  localparam logic [11:0] PKM_KEY_STRIDE = 12'h010;
  localparam logic [11:0] PKM_MIRROR     = 12'h080;
  localparam logic [11:0] PKM_CTRL       = 12'h100;
  localparam logic [11:0] PKM_STATUS     = 12'h104;
  localparam logic [11:0] PKM_ERRFLAG    = 12'h108;
  localparam int          PKM_CTRL_PLCIND = 8;
  localparam logic [8:0]  PKM_CTRL_RST   = 9'h000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    PKM_HW_X100 = 4'h0, PKM_HW_X10  = 4'h1, PKM_HW_X1    = 4'h2,
    PKM_JOG_1   = 4'h3, PKM_JOG_10  = 4'h4, PKM_JOG_100  = 4'h5,
    PKM_JOG_1K  = 4'h6, PKM_JOG_10K = 4'h7, PKM_JOG_CONT = 4'h8
  } pkm_move_t;

  typedef enum logic [1:0] {
    PKM_CH_IDLE = 2'b00,
    PKM_CH_RUN  = 2'b01,
    PKM_CH_SUSP = 2'b10,
    PKM_CH_HOLD = 2'b11
  } pkm_ch_state_t;

  typedef struct packed {
    logic [14:0] jog;
    logic [15:0] keys;
    logic [4:0]  feed_code;
    logic [3:0]  move_code;
    logic [4:0]  spin_code;
  } pkm_panel_t;

  typedef struct packed {
    logic emergency_ok_n;
    logic stop_n;
    logic block_transfer_inhibit_n;
    logic cycle_start_grant;
    logic block_end;
    logic axis_stopped;
    logic program_done;
    logic approach_move;
    logic indep_at_target;
  } pkm_ch_in_t;

  typedef struct packed {
    logic run;
    logic axis_abort;
    logic spindle_abort;
    logic gap_control_on;
    logic indep_cnc_hold;
    logic indep_plc_hold;
  } pkm_ch_out_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [95:0] pkm_words(input pkm_panel_t p);
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w1 = {1'b0, p.jog, 16'h0000};
    w2 = {4'h0, p.move_code, 3'h0, p.feed_code, p.keys & PKM_W2_KEY_MASK};
    w3 = {27'h0000000, p.spin_code};
    return {w3, w2, w1};
  endfunction : pkm_words

  function automatic logic pkm_used(input pkm_panel_t p);
    return (|p.jog) || (|(p.keys & PKM_W2_KEY_MASK));
  endfunction : pkm_used

endpackage : pkm_pkg

// [hw/pkm_key_mem.sv]
// key word store: one 96-bit entry per panel plus the last-used mirror
`timescale 1ns/1ps
`default_nettype none
module pkm_key_mem
  import pkm_pkg::*;
#(
  parameter int DEPTH = PKM_SETS,
  parameter int AW    = 4
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [95:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [95:0]   rdata
);

  logic [95:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule : pkm_key_mem
`default_nettype wire

// [hw/pkm_top.sv]
// top: panel key words, per-channel motion inhibit marks, apb register slave
`timescale 1ns/1ps
`default_nettype none
module pkm_top
  import pkm_pkg::*;
#(
  parameter int NPANEL = PKM_PANELS,
  parameter int NCH    = PKM_CHANNELS
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire pkm_panel_t         panel_in   [NPANEL],
  input  wire pkm_ch_in_t         ch_in      [NCH],
  output var  pkm_ch_out_t        ch_out     [NCH],
  output var  logic [14:0]        jog_cmd    [NCH],
  output var  logic               stop_key_pressed,
  output var  logic               spin_ovr_up,
  output var  logic               spin_ovr_down,
  output var  logic [3:0]         move_sel,
  output var  logic [4:0]         feed_ovr_code,
  output var  logic [4:0]         spin_ovr_code
);

  // ----------------------------------------
  // key scan
  // ----------------------------------------
  logic [3:0]  scan_idx;
  logic [2:0]  last_panel;
  pkm_panel_t  scan_panel;
  logic        scan_mirror;
  logic [95:0] scan_words;
  logic [95:0] mem_rdata;
  logic [3:0]  mem_raddr;
  logic [95:0] mirror_words;
  pkm_panel_t  mirror_panel;
  logic [8:0]  ctrl;
  logic        spin_switch;

  assign scan_mirror  = (scan_idx == 4'(NPANEL));
  assign scan_panel   = scan_mirror ? panel_in[last_panel] : panel_in[scan_idx[2:0]];
  assign scan_words   = pkm_words(scan_panel);
  assign mirror_panel = panel_in[last_panel];
  assign mirror_words = pkm_words(mirror_panel);
  assign spin_switch  = ctrl[last_panel];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scan_idx <= 4'h0;
    end else if (ce) begin
      scan_idx <= scan_mirror ? 4'h0 : scan_idx + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_panel <= 3'h0;
    end else if (ce && !scan_mirror && pkm_used(scan_panel)) begin
      last_panel <= scan_idx[2:0];
    end
  end

  pkm_key_mem #(
    .DEPTH (PKM_SETS),
    .AW    (4)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (1'b1),
    .waddr (scan_idx),
    .wdata (scan_words),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ----------------------------------------
  // decoded panel selectors
  // ----------------------------------------
  logic next_ovr_up;
  logic next_ovr_dn;


  assign next_ovr_up = !spin_switch && mirror_words[32 + PKM_W2_OVR_UP];
  assign next_ovr_dn = !spin_switch && mirror_words[32 + PKM_W2_OVR_DN];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spin_ovr_up      <= 1'b0;
      spin_ovr_down    <= 1'b0;
      stop_key_pressed <= 1'b0;
      move_sel         <= 4'h0;
      feed_ovr_code    <= 5'h00;
      spin_ovr_code    <= 5'h00;
    end else if (ce) begin
      spin_ovr_up      <= next_ovr_up;
      spin_ovr_down    <= next_ovr_dn;
      stop_key_pressed <= mirror_words[32 + PKM_W2_STOP];
      move_sel         <= mirror_words[32 + PKM_W2_MOVE_LSB +: 4];
      feed_ovr_code    <= mirror_words[32 + PKM_W2_FEED_LSB +: 5];
      spin_ovr_code    <= mirror_words[64 +: 5];
    end
  end

  // ----------------------------------------
  // channel marks
  // ----------------------------------------
  pkm_ch_state_t ch_state   [NCH];
  pkm_ch_state_t next_state [NCH];
  logic [NCH-1:0] emerg_set;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      next_state[c] = ch_state[c];
      emerg_set[c]  = !ch_in[c].emergency_ok_n;
      if (!ch_in[c].emergency_ok_n) begin
        next_state[c] = PKM_CH_IDLE;
      end else begin
        case (ch_state[c])
          PKM_CH_IDLE: begin
            if (ch_in[c].cycle_start_grant && ch_in[c].stop_n) begin
              next_state[c] = PKM_CH_RUN;
            end
          end
          PKM_CH_RUN: begin
            // stop mark acts as STOP key
            if (!ch_in[c].stop_n || stop_key_pressed) begin
              next_state[c] = PKM_CH_SUSP;
            end else if (ch_in[c].program_done) begin
              next_state[c] = PKM_CH_IDLE;
            end else if (!ch_in[c].block_transfer_inhibit_n && ch_in[c].block_end
                         && ch_in[c].axis_stopped) begin
              next_state[c] = PKM_CH_HOLD;
            end
          end
          PKM_CH_SUSP: begin
            // resume needs stop high and start
            if (ch_in[c].stop_n && ch_in[c].cycle_start_grant) begin
              next_state[c] = PKM_CH_RUN;
            end
          end
          PKM_CH_HOLD: begin
            if (!ch_in[c].stop_n) begin
              next_state[c] = PKM_CH_SUSP;
            end else if (ch_in[c].block_transfer_inhibit_n) begin
              next_state[c] = PKM_CH_RUN;
            end
          end
          default: next_state[c] = PKM_CH_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rst_n) begin
        ch_state[c] <= PKM_CH_IDLE;
        ch_out[c]   <= '0;
        jog_cmd[c]  <= 15'h0000;
      end else if (ce) begin
        ch_state[c]              <= next_state[c];
        ch_out[c].run            <= (next_state[c] == PKM_CH_RUN);
        ch_out[c].axis_abort     <= !ch_in[c].emergency_ok_n;
        ch_out[c].spindle_abort  <= !ch_in[c].emergency_ok_n;
        ch_out[c].gap_control_on <= !(next_state[c] == PKM_CH_SUSP && ch_in[c].approach_move);
        ch_out[c].indep_cnc_hold <= !ch_in[c].block_transfer_inhibit_n && ch_in[c].indep_at_target;
        ch_out[c].indep_plc_hold <= !ch_in[c].block_transfer_inhibit_n && ch_in[c].indep_at_target
                                    && ctrl[PKM_CTRL_PLCIND];
        jog_cmd[c]               <= (ch_in[c].block_transfer_inhibit_n && ch_in[c].emergency_ok_n)
                                    ? mirror_panel.jog : 15'h0000;
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic        acc;
  logic        wr_acc;
  logic        rd_wait;
  logic        hit_key;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_err;
  logic        mapped;
  logic [1:0]  key_word;
  logic [NCH-1:0] err_flag;
  logic [NCH-1:0] next_err;
  logic [31:0] status_word;
  logic [31:0] key_rd;

  assign acc      = psel && penable;
  assign hit_key  = (paddr < 12'h090) && (paddr[3:2] != 2'b11) && (paddr[1:0] == 2'b00);
  assign hit_ctrl = (paddr == PKM_CTRL);
  assign hit_stat = (paddr == PKM_STATUS);
  assign hit_err  = (paddr == PKM_ERRFLAG);
  assign mapped   = hit_ctrl || hit_stat || hit_err || (hit_key && !pwrite);
  assign key_word = paddr[3:2];
  assign mem_raddr = paddr[7:4];
  assign key_rd   = (key_word == 2'd0) ? mem_rdata[31:0]
                  : (key_word == 2'd1) ? mem_rdata[63:32] : mem_rdata[95:64];
  assign wr_acc   = acc && pwrite && pready;
  assign status_word = {20'h00000, last_panel, 1'b0, ch_state[3], ch_state[2], ch_state[1], ch_state[0]};
  assign next_err = emerg_set | (err_flag & ~((wr_acc && hit_err) ? pwdata[NCH-1:0] : '0));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl     <= PKM_CTRL_RST;
      err_flag <= '0;
    end else if (ce) begin
      err_flag <= next_err;
      if (wr_acc && hit_ctrl) begin
        ctrl <= pwdata[8:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_wait <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      rd_wait <= acc && !pready && !rd_wait && hit_key && !pwrite;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (acc && !pready && (rd_wait || !(hit_key && !pwrite))) begin
        pready  <= 1'b1;
        pslverr <= !mapped;
        if (!pwrite) begin
          prdata <= hit_key ? key_rd
                  : hit_ctrl ? {23'h000000, ctrl}
                  : hit_stat ? status_word
                  : hit_err ? {28'h0000000, err_flag} : 32'h00000000;
        end
      end
    end
  end

endmodule : pkm_top
`default_nettype wire

// [testbench/pkm_plc_model.sv]
// plc model: drives the per-channel control marks
`timescale 1ns/1ps
`default_nettype none
module pkm_plc_model
  import pkm_pkg::*;
#(
  parameter int NCH = PKM_CHANNELS
) (
  input  wire logic           rst_n,
  input  wire logic [NCH-1:0] estop_button_input,
  input  wire pkm_ch_in_t     req   [NCH],
  output var  pkm_ch_in_t     ch_in [NCH]
);
  // marks always driven, safe in reset
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_in[i] = req[i];
      ch_in[i].emergency_ok_n = req[i].emergency_ok_n & estop_button_input[i] & rst_n;
    end
  end
endmodule : pkm_plc_model
`default_nettype wire

// [testbench/pkm_top_assertions.sv]
// checker: timing relations on the top ports
`timescale 1ns/1ps
`default_nettype none
module pkm_top_assertions
  import pkm_pkg::*;
#(
  parameter int NCH = PKM_CHANNELS
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire pkm_ch_in_t  ch_in   [NCH],
  input wire pkm_ch_out_t ch_out  [NCH],
  input wire logic [14:0] jog_cmd [NCH]
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_emerg_abort: assert property (rst_n && ce && !ch_in[0].emergency_ok_n |=> ch_out[0].axis_abort && !ch_out[0].run)
    else $error("emergency did not abort motion");
  a_emerg_jog: assert property (rst_n && ce && !ch_in[0].emergency_ok_n |=> jog_cmd[0] == 15'h0000)
    else $error("jog passed during emergency");
  a_inhib_jog: assert property (rst_n && ce && !ch_in[0].block_transfer_inhibit_n |=> jog_cmd[0] == 15'h0000)
    else $error("jog passed during inhibit");
  a_stop_run: assert property (rst_n && ce && !ch_in[0].stop_n |=> !ch_out[0].run)
    else $error("run kept while stopped");
  a_stop_spindle: assert property (rst_n && ce && !ch_in[0].stop_n && ch_in[0].emergency_ok_n
    |=> !ch_out[0].spindle_abort)
    else $error("stop aborted spindle");
  a_gap_keep: assert property (rst_n && ce && !ch_in[0].approach_move |=> ch_out[0].gap_control_on)
    else $error("gap control dropped");
  a_indep_hold: assert property (rst_n && ce && !ch_in[0].block_transfer_inhibit_n && ch_in[0].indep_at_target
    |=> ch_out[0].indep_cnc_hold)
    else $error("independent move not held");
  a_key_refuse: assert property (pready && psel && pwrite && paddr < 12'h100 |-> pslverr)
    else $error("key word write accepted");
endmodule : pkm_top_assertions
bind pkm_top pkm_top_assertions #(.NCH(NCH)) chk_u (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .ch_in(ch_in), .ch_out(ch_out),
  .jog_cmd(jog_cmd));
`default_nettype wire

// [testbench/tb.sv]
// testbench: key words, channel marks and register access
`timescale 1ns/1ps
`default_nettype none
module tb
  import pkm_pkg::*;
;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pkm_panel_t  panel_in [PKM_PANELS];
  pkm_ch_in_t  ch_in [PKM_CHANNELS], req [PKM_CHANNELS];
  pkm_ch_out_t ch_out [PKM_CHANNELS];
  logic [14:0] jog_cmd [PKM_CHANNELS];
  logic        stop_key_pressed, spin_ovr_up, spin_ovr_down;
  logic [3:0]  move_sel, estop_button_input;
  logic [4:0]  feed_ovr_code, spin_ovr_code;
  int          num_errors, samples_checked;
  pkm_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_in(panel_in), .ch_in(ch_in), .ch_out(ch_out), .jog_cmd(jog_cmd),
    .stop_key_pressed(stop_key_pressed), .spin_ovr_up(spin_ovr_up), .spin_ovr_down(spin_ovr_down),
    .move_sel(move_sel), .feed_ovr_code(feed_ovr_code), .spin_ovr_code(spin_ovr_code));
  pkm_plc_model plc_u (.rst_n(rst_n), .estop_button_input(estop_button_input), .req(req), .ch_in(ch_in));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic start0;
    req[0].cycle_start_grant <= 1'b1;
    cyc(1);
    req[0].cycle_start_grant <= 1'b0;
    cyc(4);
  endtask : start0
  task automatic t_keys;
    panel_in[2] <= {15'h4001, 16'hFFFF, 5'h16, 4'h8, 5'h16};
    cyc(12);
    rdchk(12'h020, 32'h4001_0000);
    rdchk(12'h024, 32'h0816_E7FF);
    rdchk(12'h028, 32'h0000_0016);
    rdchk(12'h084, 32'h0816_E7FF);
    rdchk(12'h070, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      panel_in[2].move_code <= 4'(i);
      panel_in[2].feed_code <= 5'(i + 14);
      panel_in[2].spin_code <= 5'(i);
      cyc(12);
      check(32'(move_sel), 32'(i));
      check(32'(feed_ovr_code), 32'(i + 14));
      check(32'(spin_ovr_code), 32'(i));
    end
    panel_in[2].jog <= 15'h0000;
    cyc(12);
    rdchk(12'h020, 32'h0000_0000);
    apb(1'h1, 12'h020, 32'hFFFF_FFFF);
    check(er, 1'h1);
    rdchk(12'h200, 32'h0);
    check(er, 1'h1);
    $display("keys test done");
  endtask : t_keys
  task automatic t_spin;
    panel_in[2].keys <= 16'h0011;
    cyc(12);
    check(spin_ovr_up, 1'h1);
    check(spin_ovr_down, 1'h1);
    apb(1'h1, PKM_CTRL, 32'h4);
    cyc(4);
    check(spin_ovr_up, 1'h0);
    check(spin_ovr_down, 1'h0);
    rdchk(12'h024, 32'h0816_0011);
    $display("spindle switch test done");
  endtask : t_spin
  task automatic t_emerg;
    start0;
    check(ch_out[0].run, 1'h1);
    estop_button_input[0] <= 1'b0;
    cyc(4);
    check(ch_out[0].axis_abort, 1'h1);
    check(ch_out[0].spindle_abort, 1'h1);
    rdchk(PKM_ERRFLAG, 32'h1);
    start0;
    check(ch_out[0].run, 1'h0);
    panel_in[2].jog <= 15'h0001;
    req[1].emergency_ok_n <= 1'b0;
    cyc(12);
    check(jog_cmd[0], 15'h0);
    check(jog_cmd[2], 15'h1);
    check(ch_out[1].axis_abort, 1'h1);
    estop_button_input[0] <= 1'b1;
    req[1].emergency_ok_n <= 1'b1;
    cyc(4);
    apb(1'h1, PKM_ERRFLAG, 32'hF);
    rdchk(PKM_ERRFLAG, 32'h0);
    $display("emergency test done");
  endtask : t_emerg
  task automatic t_stop;
    start0;
    req[0].stop_n <= 1'b0;
    req[0].approach_move <= 1'b1;
    panel_in[2].keys <= 16'h0080;
    cyc(12);
    check(ch_out[0].run, 1'h0);
    check(ch_out[0].spindle_abort, 1'h0);
    check(ch_out[0].gap_control_on, 1'h0);
    check(stop_key_pressed, 1'h1);
    rdchk(PKM_STATUS, 32'h0402);
    panel_in[2].keys <= 16'h0000;
    req[0].approach_move <= 1'b0;
    req[0].stop_n <= 1'b1;
    cyc(12);
    check(ch_out[0].run, 1'h0);
    check(ch_out[0].gap_control_on, 1'h1);
    start0;
    check(ch_out[0].run, 1'h1);
    $display("stop test done");
  endtask : t_stop
  task automatic t_inhib;
    req[0].block_transfer_inhibit_n <= 1'b0;
    req[0].block_end <= 1'b1;
    panel_in[2].jog <= 15'h0002;
    cyc(12);
    check(ch_out[0].run, 1'h1);
    check(jog_cmd[0], 15'h0);
    check(jog_cmd[1], 15'h2);
    req[0].axis_stopped <= 1'b1;
    req[0].indep_at_target <= 1'b1;
    cyc(4);
    req[0].block_end <= 1'b0;
    check(ch_out[0].run, 1'h0);
    check(ch_out[0].indep_cnc_hold, 1'h1);
    check(ch_out[0].indep_plc_hold, 1'h0);
    rdchk(PKM_STATUS, 32'h0403);
    apb(1'h1, PKM_CTRL, 32'h100);
    cyc(4);
    check(ch_out[0].indep_plc_hold, 1'h1);
    req[0].block_transfer_inhibit_n <= 1'b1;
    cyc(4);
    check(ch_out[0].run, 1'h1);
    $display("inhibit test done");
  endtask : t_inhib
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    estop_button_input = 4'hF;
    num_errors = 0;
    samples_checked = 0;
    for (int i = 0; i < PKM_PANELS; i++) panel_in[i] = '0;
    for (int i = 0; i < PKM_CHANNELS; i++) req[i] = 9'h1C0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(12);
    t_keys;
    t_spin;
    t_emerg;
    t_stop;
    t_inhib;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule : tb
`default_nettype wire
